// [rtl/csb_serial_port.sv]
`timescale 1ns/1ps
module csb_serial_port (
    // System
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [31:0]         adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // Serial pins
    input  wire logic                serial_clock_pin_i,
    input  wire logic                serial_in_pin_i,
    output csb_pkg::csb_pins_t       pins_o,
    // Event
    output logic                     serial_done_irq_o
);
    import csb_pkg::*;

    csb_ctl_one_t      ctl_one;
    csb_ctl_two_t      ctl_two;
    csb_status_t       status;
    csb_state_t        state;
    logic [WORD_W-1:0] buffer_ram [BUF_DEPTH];
    logic              busy;
    logic              need_read;
    logic              need_write;
    logic              go;
    logic [2:0]        word_idx;
    logic [2:0]        bit_idx;
    logic [7:0]        tx_sh;
    logic [7:0]        tx_next;
    logic [7:0]        rx_sh;
    logic              sck_q;
    logic              so_q;
    logic [DIV_W-1:0]  div_cnt;
    logic [5:0]        gap_cnt;
    logic [1:0]        pin_lvl;
    logic              sck_prev;

    // Decode helpers
    function automatic logic is_buf(input logic [ADR_W-1:0] i);
        return (i >= IDX_BUF_FIRST) && (i <= IDX_BUF_LAST);
    endfunction

    function automatic logic [2:0] buf_slot(input logic [ADR_W-1:0] i);
        logic [ADR_W-1:0] d;
        d = i - IDX_BUF_FIRST;
        return d[2:0];
    endfunction

    function automatic logic has_tx(input logic [2:0] m);
        return (m == MODE_TX8) || (m == MODE_TX4) || (m == MODE_TRX8);
    endfunction

    function automatic logic has_rx(input logic [2:0] m);
        return (m == MODE_RX8) || (m == MODE_RX4) || (m == MODE_TRX8);
    endfunction

    function automatic logic is_ext(input logic [2:0] c);
        return (c != CS_DIV13) && (c != CS_DIV8) && (c != CS_DIV6) && (c != CS_DIV5);
    endfunction

    function automatic logic [DIV_W-1:0] half_of(input logic [2:0] c);
        case (c)
            CS_DIV8: return HALF_DIV8;
            CS_DIV6: return HALF_DIV6;
            CS_DIV5: return HALF_DIV5;
            default: return HALF_DIV13;
        endcase
    endfunction

    function automatic logic [5:0] gap_of(input logic [1:0] w);
        case (w)
            2'h1:    return GAP_HALVES_1;
            2'h2:    return GAP_HALVES_2;
            2'h3:    return GAP_HALVES_3;
            default: return GAP_HALVES_0;
        endcase
    endfunction

    // Bus decode; side effects land on the edge that ends the cycle
    logic [ADR_W-1:0] idx;
    csb_ctl_one_t     wr_ctl;
    logic             req;
    logic             hi_zero;
    logic             wr_hit;
    logic             rd_hit;
    logic             wr_one;
    logic             mode_chg;
    logic             buf_wr;
    logic             buf_rd;

    assign idx      = adr_i[ADR_W+1:2];
    assign wr_ctl   = dat_i[7:0];
    assign req      = cyc_i & stb_i;
    assign hi_zero  = (adr_i[31:ADR_W+2] == '0);
    assign wr_hit   = req & ack_o & we_i & sel_i[0] & hi_zero;
    assign rd_hit   = req & ack_o & ~we_i & hi_zero;
    assign wr_one   = wr_hit & (idx == IDX_CTL_ONE);
    assign mode_chg = wr_one & (wr_ctl.mode != ctl_one.mode);
    assign buf_wr   = wr_hit & is_buf(idx);
    assign buf_rd   = rd_hit & is_buf(idx);

    // Transfer condition decode
    logic       ext;
    logic       tx_on;
    logic       rx_on;
    logic       len4;
    logic [2:0] last_bit;
    logic       tick;
    logic       fall_ev;
    logic       rise_ev;
    logic       wend;
    logic       batch_end;
    logic       rx_drop;
    logic       wait_need;
    logic [7:0] rx_next;
    logic [7:0] rx_word;
    logic [2:0] nxt_idx;

    assign ext      = is_ext(ctl_one.clk_src);
    assign tx_on    = has_tx(ctl_one.mode);
    assign rx_on    = has_rx(ctl_one.mode);
    assign len4     = (ctl_one.mode == MODE_TX4) || (ctl_one.mode == MODE_RX4);
    assign last_bit = len4 ? LAST_BIT_4 : LAST_BIT_8;

    assign tick = ~ext && ((state == ST_SHIFT) || (state == ST_GAP))
               && (div_cnt == half_of(ctl_one.clk_src) - 13'h0001);

    // Leading edge is the pin's fall, trailing edge its rise
    assign fall_ev = (state == ST_SHIFT)
                   && (ext ? (sck_prev & ~pin_lvl[0]) : (tick & sck_q));
    assign rise_ev = (state == ST_SHIFT)
                   && (ext ? (~sck_prev & pin_lvl[0]) : (tick & ~sck_q));

    assign wend      = rise_ev & (bit_idx == last_bit);
    assign batch_end = wend & (word_idx == ctl_two.count);
    assign rx_drop   = wend & rx_on & ext & need_read;
    assign wait_need = tx_on ? need_write : need_read;
    assign nxt_idx   = (word_idx == ctl_two.count) ? 3'h0 : word_idx + 3'h1;

    assign rx_next = {pin_lvl[1], rx_sh[7:1]};
    assign rx_word = len4 ? {4'h0, rx_next[7:4]} : rx_next;

    csb_sync3 #(
        .WIDTH (2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({serial_in_pin_i, serial_clock_pin_i}),
        .level_o (pin_lvl)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_prev <= 1'b1;
        end else begin
            sck_prev <= pin_lvl[0];
        end
    end

    // Wishbone answer: ack one cycle after the request, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req & ~ack_o;
            dat_o <= 32'h0000_0000;
            if (req && !ack_o && !we_i && hi_zero) begin
                if (idx == IDX_CTL_ONE) begin
                    dat_o[7:0] <= ctl_one;
                end else if (idx == IDX_CTL_TWO) begin
                    dat_o[7:0] <= ctl_two;
                end else if (idx == IDX_STATUS) begin
                    dat_o[7:0] <= status;
                end else if (is_buf(idx)) begin
                    dat_o[7:0] <= buffer_ram[buf_slot(idx)];
                end
            end
        end
    end

    always_comb begin
        status            = '0;
        status.busy       = busy;
        status.waiting    = (state == ST_WAIT);
        status.need_read  = need_read;
        status.need_write = need_write;
    end

    // Control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_one <= CTL_ONE_RST;
        end else if (wr_one) begin
            ctl_one <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_two <= CTL_TWO_RST;
        end else if (wr_hit && idx == IDX_CTL_TWO) begin
            ctl_two <= dat_i[7:0];
        end
    end

    // Start is a one-shot taken only while idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go <= 1'b0;
        end else begin
            go <= wr_one && wr_ctl.start && !wr_ctl.abort && state == ST_IDLE
               && (has_tx(wr_ctl.mode) || has_rx(wr_ctl.mode));
        end
    end

    // Buffer: received words win over a same-cycle software write
    always_ff @(posedge clk_i) begin
        if (rst_i || mode_chg) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buffer_ram[i] <= '0;
            end
        end else if (wend && rx_on && !rx_drop) begin
            buffer_ram[word_idx] <= rx_word;
        end else if (buf_wr) begin
            buffer_ram[buf_slot(idx)] <= dat_i[7:0];
        end
    end

    // Service flags; a batch end in the same cycle as an access wins
    always_ff @(posedge clk_i) begin
        if (rst_i || go) begin
            need_read  <= 1'b0;
            need_write <= 1'b0;
        end else begin
            if (batch_end && rx_on) begin
                need_read <= 1'b1;
            end else if (buf_rd) begin
                need_read <= 1'b0;
            end
            if (batch_end && tx_on) begin
                need_write <= 1'b1;
            end else if (buf_wr) begin
                need_write <= 1'b0;
            end
        end
    end

    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i || ctl_one.abort) begin
            state    <= ST_IDLE;
            busy     <= 1'b0;
            word_idx <= 3'h0;
            bit_idx  <= 3'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go) begin
                        state    <= ST_SHIFT;
                        busy     <= 1'b1;
                        word_idx <= 3'h0;
                        bit_idx  <= 3'h0;
                    end
                end
                ST_SHIFT: begin
                    if (rise_ev) begin
                        bit_idx <= wend ? 3'h0 : bit_idx + 3'h1;
                    end
                    if (wend) begin
                        word_idx <= batch_end ? 3'h0 : word_idx + 3'h1;
                        if (rx_drop || !ctl_one.start) begin
                            state <= ST_IDLE;
                            busy  <= 1'b0;
                        end else if (!ext && batch_end) begin
                            state <= ST_WAIT;
                        end else if (!ext && rx_on) begin
                            state <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    if (tick && gap_cnt == gap_of(ctl_two.wait_sel) - 6'h01) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_WAIT: begin
                    if (!ctl_one.start) begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                    end else if (!wait_need) begin
                        state <= rx_on ? ST_GAP : ST_SHIFT;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // Internal clock divider and gap counter
    always_ff @(posedge clk_i) begin
        if (rst_i || tick || !(state == ST_SHIFT || state == ST_GAP)) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 13'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state != ST_GAP) begin
            gap_cnt <= 6'h00;
        end else if (tick) begin
            gap_cnt <= gap_cnt + 6'h01;
        end
    end

    // Clock pin idles high outside shifting, so a wait never splits a bit
    always_ff @(posedge clk_i) begin
        if (rst_i || state != ST_SHIFT) begin
            sck_q <= 1'b1;
        end else if (tick) begin
            sck_q <= ~sck_q;
        end
    end

    // Transmit path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_sh   <= 8'h00;
            tx_next <= 8'h00;
        end else begin
            if (go || (state == ST_WAIT && !wait_need)) begin
                tx_sh <= buffer_ram[word_idx];
            end else if (wend) begin
                tx_sh <= tx_next;
            end
            if (fall_ev && bit_idx == 3'h0) begin
                tx_next <= buffer_ram[nxt_idx];
            end
        end
    end

    // Output holds its old level until the first falling edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            so_q <= 1'b1;
        end else if (fall_ev && tx_on) begin
            so_q <= tx_sh[bit_idx];
        end
    end

    // Receive path
    always_ff @(posedge clk_i) begin
        if (rst_i || go) begin
            rx_sh <= 8'h00;
        end else if (rise_ev) begin
            rx_sh <= wend ? 8'h00 : rx_next;
        end
    end

    // Done pulse, one cycle per completed batch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_done_irq_o <= 1'b0;
        end else begin
            serial_done_irq_o <= batch_end & ~rx_drop;
        end
    end

    always_comb begin
        pins_o                     = '0;
        pins_o.serial_clock_pin    = sck_q;
        pins_o.serial_clock_pin_oe = ~ext & (tx_on | rx_on);
        pins_o.serial_out_pin      = so_q;
        pins_o.serial_out_pin_oe   = tx_on;
    end

endmodule

// [rtl/csb_pkg.sv]
package csb_pkg;

    // Register indices; byte address is four times the index
    localparam int unsigned     ADR_W         = 14;
    localparam logic [13:0]     IDX_CTL_ONE   = 14'h0FD0;
    localparam logic [13:0]     IDX_CTL_TWO   = 14'h0FD1;
    localparam logic [13:0]     IDX_STATUS    = 14'h0FD2;
    localparam logic [13:0]     IDX_BUF_FIRST = 14'h0FD8;
    localparam logic [13:0]     IDX_BUF_LAST  = 14'h0FDF;

    localparam int unsigned     BUF_DEPTH     = 8;
    localparam int unsigned     WORD_W        = 8;
    localparam logic [2:0]      LAST_BIT_8    = 3'h7;
    localparam logic [2:0]      LAST_BIT_4    = 3'h3;

    localparam logic [7:0]      CTL_ONE_RST   = 8'h00;
    localparam logic [7:0]      CTL_TWO_RST   = 8'h00;

    // Transfer mode codes
    localparam logic [2:0]      MODE_TX8      = 3'h0;
    localparam logic [2:0]      MODE_TX4      = 3'h2;
    localparam logic [2:0]      MODE_TRX8     = 3'h4;
    localparam logic [2:0]      MODE_RX8      = 3'h5;
    localparam logic [2:0]      MODE_RX4      = 3'h6;

    // Clock source codes; any other code selects the external clock
    localparam logic [2:0]      CS_DIV13      = 3'h0;
    localparam logic [2:0]      CS_DIV8       = 3'h1;
    localparam logic [2:0]      CS_DIV6       = 3'h2;
    localparam logic [2:0]      CS_DIV5       = 3'h3;
    localparam logic [2:0]      CS_EXT        = 3'h7;

    // Half periods of the internal serial clock in system cycles
    localparam int unsigned     DIV_W         = 13;
    localparam logic [12:0]     HALF_DIV13    = 13'h1000;
    localparam logic [12:0]     HALF_DIV8     = 13'h0080;
    localparam logic [12:0]     HALF_DIV6     = 13'h0020;
    localparam logic [12:0]     HALF_DIV5     = 13'h0010;

    // Inter-word wait in serial clock half periods
    localparam logic [5:0]      GAP_HALVES_0  = 6'h04;
    localparam logic [5:0]      GAP_HALVES_1  = 6'h08;
    localparam logic [5:0]      GAP_HALVES_2  = 6'h10;
    localparam logic [5:0]      GAP_HALVES_3  = 6'h20;

    typedef struct packed {
        logic       start;
        logic       abort;
        logic [2:0] mode;
        logic [2:0] clk_src;
    } csb_ctl_one_t;

    typedef struct packed {
        logic [2:0] unused;
        logic [1:0] wait_sel;
        logic [2:0] count;
    } csb_ctl_two_t;

    typedef struct packed {
        logic       busy;
        logic       waiting;
        logic       need_read;
        logic       need_write;
        logic [3:0] zero;
    } csb_status_t;

    typedef struct packed {
        logic serial_clock_pin;
        logic serial_clock_pin_oe;
        logic serial_out_pin;
        logic serial_out_pin_oe;
    } csb_pins_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SHIFT = 4'b0010,
        ST_GAP   = 4'b0100,
        ST_WAIT  = 4'b1000
    } csb_state_t;

endpackage

// [rtl/csb_sync3.sv]
`timescale 1ns/1ps
module csb_sync3 #(
    parameter int unsigned WIDTH = 2
) (
    // System
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Pins
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    always_ff @(posedge clk_i) begin
        s1 <= async_i;
        s2 <= s1;
        s3 <= s2;
    end

    // Level follows only once two stages agree, filtering one-cycle glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= '1;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i]) begin
                    level_o[i] <= s3[i];
                end
            end
        end
    end
endmodule

// [sim/csb_serial_port_sva.sv]
`timescale 1ns/1ps
module csb_serial_port_chk
    import csb_pkg::*;
(
    // System
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Serial
    input wire logic        serial_clock_pin_i,
    input wire logic        serial_in_pin_i,
    input wire csb_pins_t   pins_o,
    input wire logic        serial_done_irq_o
);
    logic [13:0] lo_cnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Longest internal half period is 4096 cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || pins_o.serial_clock_pin)
            lo_cnt <= 14'h0000;
        else
            lo_cnt <= lo_cnt + 14'h0001;
    end

    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged next cycle");
    ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    unmapped_read_a: assert property (ack_o && !we_i && adr_i[31:16] != 16'h0000
        |-> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    irq_pulse_a: assert property (serial_done_irq_o |=> !serial_done_irq_o)
        else $error("done pulse longer than one cycle");
    irq_idle_a: assert property (serial_done_irq_o |-> pins_o.serial_clock_pin)
        else $error("clock pin low at batch end");
    tx_edge_a: assert property ($changed(pins_o.serial_out_pin)
        && pins_o.serial_clock_pin_oe && pins_o.serial_out_pin_oe
        |-> !pins_o.serial_clock_pin)
        else $error("data out changed while clock high");
    low_min_a: assert property ($fell(pins_o.serial_clock_pin)
        |-> !pins_o.serial_clock_pin [*8])
        else $error("clock low phase too short");
    low_max_a: assert property (lo_cnt <= 14'h1000)
        else $error("clock low phase too long");
endmodule

bind csb_serial_port csb_serial_port_chk i_csb_serial_port_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .serial_clock_pin_i(serial_clock_pin_i), .serial_in_pin_i(serial_in_pin_i),
    .pins_o(pins_o), .serial_done_irq_o(serial_done_irq_o)
);

// [sim/csb_link_partner.sv]
`timescale 1ns/1ps
module csb_link_partner (
    // Link
    input  wire logic        clk_line_i,
    input  wire logic        so_i,
    // Control
    input  wire logic        load_i,
    input  wire logic        ext_go_i,
    input  wire logic [15:0] word_i,
    // Outputs
    output logic             ext_sck_o,
    output logic             sin_o,
    output logic [7:0]       rx_o
);
    logic [15:0] tx_q;

    initial begin
        ext_sck_o = 1'b1;
        sin_o = 1'b0;
        rx_o = 8'h00;
        tx_q = 16'h0000;
    end
    // Line shows a wrong bit until the first leading edge
    always @(posedge load_i) begin
        tx_q = word_i;
        sin_o = ~word_i[0];
    end
    always @(negedge clk_line_i) begin
        sin_o = tx_q[0];
        tx_q = {~tx_q[0], tx_q[15:1]};
    end
    always @(posedge clk_line_i) begin
        rx_o = {so_i, rx_o[7:1]};
    end
    // Eight pulses, each level 8 system cycles; idle high between frames
    always @(posedge ext_go_i) begin
        // Off the system clock edge, so the pin never races the synchroniser
        #3;
        repeat (8) begin
            #80 ext_sck_o = 1'b0;
            #80 ext_sck_o = 1'b1;
        end
    end
endmodule

// [sim/test_clocked_serial_buffered_port.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module test_clocked_serial_buffered_port;
    import csb_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [31:0] adr_i = 32'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    csb_pins_t   pins_o;
    logic        irq;
    logic        ext_sck;
    logic        sin;
    logic [7:0]  rx_b;
    logic        load = 1'b0;
    logic        go = 1'b0;
    logic [15:0] w = 16'h0;
    logic [7:0]  rd;
    logic [7:0]  d;
    logic [2:0]  src;
    logic [12:0] n;
    logic        held;
    logic        prev;
    integer      seed;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [2:0]  md_tab [3] = '{MODE_TX8, MODE_TRX8, MODE_TX4};
    logic [12:0] hf_tab [3] = '{HALF_DIV5, HALF_DIV6, HALF_DIV8};
    logic [13:0] rst_idx [4] = '{IDX_CTL_ONE, IDX_CTL_TWO, IDX_STATUS, IDX_BUF_LAST};
    wire logic   line = pins_o.serial_clock_pin_oe ? pins_o.serial_clock_pin : ext_sck;

    always #5 clk_i = ~clk_i;

    csb_serial_port i_csb_serial_port (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .serial_clock_pin_i(line), .serial_in_pin_i(sin), .pins_o(pins_o),
        .serial_done_irq_o(irq)
    );
    csb_link_partner i_csb_link_partner (
        .clk_line_i(line), .so_i(pins_o.serial_out_pin), .load_i(load),
        .ext_go_i(go), .word_i(w), .ext_sck_o(ext_sck), .sin_o(sin), .rx_o(rx_b)
    );

    function automatic logic [31:0] ra(input logic [13:0] i);
        return {16'h0000, i, 2'b00};
    endfunction

    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Classic single cycle; no fixed latency assumed
    task automatic wb(input logic wr, input logic [31:0] a, input logic [7:0] v);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h0, v};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wirq();
        while (irq !== 1'b1) @(posedge clk_i);
    endtask

    task automatic feed();
        w = 16'($random(seed));
        load <= 1'b1;
        @(posedge clk_i);
        load <= 1'b0;
    endtask

    task automatic rxrun(input logic [2:0] m, input logic [2:0] s, input logic [7:0] c2);
        wb(1'b1, ra(IDX_CTL_ONE), {2'b00, m, s});
        wb(1'b0, ra(IDX_BUF_FIRST), 8'h00);
        `CHK(rd, 8'h00)
        wb(1'b1, ra(IDX_CTL_TWO), c2);
        feed();
        wb(1'b1, ra(IDX_CTL_ONE), {2'b10, m, s});
        go <= (s == CS_EXT);
        `CHK(pins_o.serial_out_pin_oe, 1'b0)
        `CHK(pins_o.serial_clock_pin_oe, (s != CS_EXT))
        wirq();
        go <= 1'b0;
        wb(1'b0, ra(IDX_STATUS), 8'h00);
        `CHK(rd[7:5], {1'b1, (s != CS_EXT), 1'b1})
        wb(1'b1, ra(IDX_CTL_ONE), {2'b01, m, s});
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        seed = 32'h3fd2;
        prev = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rst_idx[k]) begin
            wb(1'b0, ra(rst_idx[k]), 8'h00);
            `CHK(rd, 8'h00)
        end
        d = 8'($random(seed)) & 8'h1F;
        wb(1'b1, ra(IDX_CTL_TWO), d);
        wb(1'b0, ra(IDX_CTL_TWO), 8'h00);
        `CHK(rd, d)
        wb(1'b0, 32'h0001_0000 + ra(IDX_CTL_TWO), 8'h00);
        `CHK(rd, 8'h00)
        wb(1'b1, ra(IDX_CTL_TWO), 8'h00);
        // One word per transmit mode (TX8, TRX8, TX4) at three clock rates
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            src = 3'(3 - i);
            wb(1'b1, ra(IDX_CTL_ONE), {2'b00, md_tab[i], src});
            wb(1'b1, ra(IDX_BUF_FIRST), d);
            feed();
            wb(1'b1, ra(IDX_CTL_ONE), {2'b10, md_tab[i], src});
            while (pins_o.serial_clock_pin !== 1'b0) begin
                held = pins_o.serial_out_pin;
                @(posedge clk_i);
            end
            `CHK(held, prev)
            n = 13'h0;
            while (pins_o.serial_clock_pin === 1'b0) begin
                n++;
                @(posedge clk_i);
            end
            `CHK(n, hf_tab[i])
            wirq();
            if (i == 2) `CHK(rx_b[7:4], d[3:0])
            else `CHK(rx_b, d)
            wb(1'b0, ra(IDX_STATUS), 8'h00);
            `CHK(rd[7:6], 2'b11)
            wb(1'b1, ra(IDX_CTL_ONE), {2'b01, md_tab[i], src});
            wb(1'b0, ra(IDX_STATUS), 8'h00);
            `CHK(rd[7], 1'b0)
            if (i == 1) begin
                wb(1'b0, ra(IDX_BUF_FIRST), 8'h00);
                `CHK(rd, w[7:0])
            end
            prev = (i == 2) ? d[3] : d[7];
        end
        rxrun(MODE_RX8, CS_DIV5, 8'h01);
        wb(1'b0, ra(IDX_BUF_FIRST), 8'h00);
        `CHK(rd, w[7:0])
        wb(1'b0, ra(IDX_BUF_FIRST + 14'h1), 8'h00);
        `CHK(rd, w[15:8])
        rxrun(MODE_RX4, CS_DIV5, 8'h00);
        wb(1'b0, ra(IDX_BUF_FIRST), 8'h00);
        `CHK(rd, {4'h0, w[3:0]})
        rxrun(MODE_RX8, CS_EXT, 8'h00);
        wb(1'b0, ra(IDX_BUF_FIRST), 8'h00);
        `CHK(rd, w[7:0])
        test_done();
    end
endmodule
